// ==== rcs_pkg.sv ====
package rcs_pkg;

	// ==========================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int OSC_HZ = 32768;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int DIV_STAGES = 15;
	localparam int UIP_LEAD_US = 244;
	localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int RESTART_MS = 500;
	localparam int RESTART_TICKS = RESTART_MS * OSC_HZ / 1000;
	localparam logic [14:0] CHAIN_UIP_START = 15'((2 ** DIV_STAGES) - UIP_LEAD_TICKS);
	localparam logic [14:0] CHAIN_RESTART = 15'((2 ** DIV_STAGES) - RESTART_TICKS);

	// ==========================================
	// Register offsets
	localparam logic [7:0] OFF_RATE_OSC = 8'h00;
	localparam logic [7:0] OFF_IRQ_FMT = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_BATTERY = 8'h0C;
	localparam logic [7:0] OFF_TIME_BASE = 8'h10;
	localparam logic [7:0] OFF_TIME_END = 8'h34;

	// Time byte indices
	localparam int TI_SEC = 0;
	localparam int TI_SEC_AL = 1;
	localparam int TI_MIN = 2;
	localparam int TI_MIN_AL = 3;
	localparam int TI_HOUR = 4;
	localparam int TI_HOUR_AL = 5;
	localparam int TI_WDAY = 6;
	localparam int TI_DATE = 7;
	localparam int TI_MONTH = 8;
	localparam int TIME_ENTRIES = 9;

	// ==========================================
	// Field positions
	localparam int A_UIP = 7;
	localparam int A_OSC_LSB = 4;
	localparam int A_RATE_LSB = 0;
	localparam int B_FREEZE = 7;
	localparam int B_PIE = 6;
	localparam int B_AIE = 5;
	localparam int B_UIE = 4;
	localparam int B_SQUARE_WAVE_ENABLE = 3;
	localparam int B_BIN = 2;
	localparam int B_HR24 = 1;
	localparam int B_DST = 0;
	localparam int C_INTERRUPT_PENDING_FLAG = 7;
	localparam int C_FLAG_LSB = 4;
	localparam int D_BATT = 7;

	// ==========================================
	// Patterns and reset values
	localparam logic [2:0] OSC_RUN = 3'b010;
	localparam logic [1:0] OSC_HOLD_HI = 2'b11;
	localparam logic [3:0] RATE_RST = 4'h0;
	localparam logic [2:0] OSC_RST = 3'b000;
	localparam logic [7:0] TIME_RST = 8'h00;

	typedef struct packed {
		logic sec_tick;
		logic uip_window;
		logic tap_edge;
		logic tap_level;
	} rcs_div_status_type;

endpackage

// ==== rcs_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcs_divider #(
	parameter int OSC_DIV = rcs_pkg::OSC_DIV
) (
	input wire logic pclk,
	input wire logic por_n,
	input wire logic ce,
	input wire logic osc_run,
	input wire logic chain_hold,
	input wire logic restart,
	input wire logic [3:0] rate_sel,
	output rcs_pkg::rcs_div_status_type status
);

	logic [15:0] pre_reg;
	logic [14:0] chain_reg;
	logic [14:0] chain_inc;
	logic osc_tick;
	logic [3:0] tap_idx;
	logic tap_valid;
	logic advance;

	if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
		$error("OSC_DIV out of range");
	end

	// ==========================================
	// Prescaler to the oscillator rate
	assign osc_tick = osc_run && (pre_reg == 16'(OSC_DIV - 1));
	assign advance = osc_tick && !chain_hold && !restart;

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pre_reg <= 16'h0000;
		end else if (ce) begin
			if (!osc_run || osc_tick) begin
				pre_reg <= 16'h0000;
			end else begin
				pre_reg <= pre_reg + 16'h0001;
			end
		end
	end

	// ==========================================
	// Up-counting chain
	assign chain_inc = chain_reg + 15'h0001;

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			chain_reg <= 15'h0000;
		end else if (ce) begin
			if (restart) begin
				// Run pattern written over a held chain still loads it
				chain_reg <= rcs_pkg::CHAIN_RESTART;
			end else if (chain_hold) begin
				chain_reg <= 15'h0000;
			end else if (osc_tick) begin
				chain_reg <= chain_inc;
			end
		end
	end

	// ==========================================
	// Tap selection
	always_comb begin
		tap_valid = (rate_sel != 4'h0);
		case (rate_sel)
			4'h1: tap_idx = 4'h6;
			4'h2: tap_idx = 4'h7;
			default: tap_idx = rate_sel - 4'h2;
		endcase
	end

	always_comb begin
		status.sec_tick = advance && (&chain_reg);
		status.uip_window = (chain_reg >= rcs_pkg::CHAIN_UIP_START);
		status.tap_level = tap_valid && chain_reg[tap_idx];
		status.tap_edge = advance && tap_valid && !chain_reg[tap_idx] && chain_inc[tap_idx];
	end

endmodule // rcs_divider
`default_nettype wire

// ==== rcs_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcs_top #(
	parameter int OSC_DIV = rcs_pkg::OSC_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic battery_good_in,
	output logic irq_n,
	output logic square_wave_out
);

	// ==========================================
	// Declarations
	logic pin_rst_n;
	logic [3:0] rate_sel_reg;
	logic [2:0] osc_ctrl_reg;
	logic freeze_reg;
	logic periodic_irq_enable_reg;
	logic alarm_irq_enable_reg;
	logic update_done_irq_enable_reg;
	logic square_wave_enable_reg;
	logic binary_format_select_reg;
	logic hour_24_reg;
	logic summer_time_enable_reg;
	logic [2:0] flags_reg;
	logic [2:0] pend_reg;
	logic [7:0] time_reg [0:rcs_pkg::TIME_ENTRIES-1];
	logic fall_done_reg;
	logic [2:0] batt_sync_reg;
	logic battery_good_flag_reg;
	logic [31:0] prdata_reg;
	logic acc_ok_reg;
	logic sqw_reg;
	rcs_pkg::rcs_div_status_type div_status;
	logic osc_run;
	logic chain_hold;
	logic restart;
	logic update_pending_flag;
	logic interrupt_pending_flag;
	logic [2:0] events;
	logic xfer_done;
	logic wr_en;
	logic rd_flags;
	logic hit;
	logic time_hit;
	logic [7:0] time_off;
	logic [3:0] time_idx;
	logic [7:0] rd_val;
	logic transfer;
	logic [7:0] sec_next;
	logic [7:0] min_next;
	logic [7:0] hour_next;
	logic fall_hit;
	logic fall_day;
	logic alarm_match;

	assign pin_rst_n = presetn && por_n;

	// ==========================================
	// Divider chain and oscillator control
	assign osc_run = (osc_ctrl_reg == rcs_pkg::OSC_RUN) || (osc_ctrl_reg[2:1] == rcs_pkg::OSC_HOLD_HI);
	assign chain_hold = (osc_ctrl_reg[2:1] == rcs_pkg::OSC_HOLD_HI);
	assign restart = wr_en && (paddr == rcs_pkg::OFF_RATE_OSC)
		&& (pwdata[rcs_pkg::A_OSC_LSB +: 3] == rcs_pkg::OSC_RUN)
		&& (osc_ctrl_reg != rcs_pkg::OSC_RUN);

	rcs_divider #(
		.OSC_DIV(OSC_DIV)
	) u_divider (
		.pclk(pclk),
		.por_n(por_n),
		.ce(ce),
		.osc_run(osc_run),
		.chain_hold(chain_hold),
		.restart(restart),
		.rate_sel(rate_sel_reg),
		.status(div_status)
	);

	// Combinational flag, so the reset pin cannot touch it
	assign update_pending_flag = div_status.uip_window && !freeze_reg && osc_run && !chain_hold;
	assign transfer = div_status.sec_tick && !freeze_reg;

	// ==========================================
	// APB slave
	assign time_off = paddr - rcs_pkg::OFF_TIME_BASE;
	assign time_idx = time_off[5:2];
	assign time_hit = (paddr >= rcs_pkg::OFF_TIME_BASE) && (paddr < rcs_pkg::OFF_TIME_END)
		&& (paddr[1:0] == 2'b00);
	assign pready = psel && penable && ce && acc_ok_reg;
	assign xfer_done = pready;
	assign pslverr = pready && !hit;
	assign wr_en = xfer_done && pwrite && hit;
	assign rd_flags = psel && !pwrite && (paddr == rcs_pkg::OFF_FLAGS);
	assign prdata = prdata_reg;

	always_comb begin
		hit = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			rcs_pkg::OFF_RATE_OSC: begin
				rd_val = {update_pending_flag, osc_ctrl_reg, rate_sel_reg};
			end
			rcs_pkg::OFF_IRQ_FMT: begin
				rd_val = {freeze_reg, periodic_irq_enable_reg, alarm_irq_enable_reg,
					update_done_irq_enable_reg, square_wave_enable_reg,
					binary_format_select_reg, hour_24_reg, summer_time_enable_reg};
			end
			rcs_pkg::OFF_FLAGS: begin
				rd_val = {interrupt_pending_flag, flags_reg, 4'h0};
			end
			rcs_pkg::OFF_BATTERY: begin
				rd_val = {battery_good_flag_reg, 7'h00};
			end
			default: begin
				if (time_hit) begin
					rd_val = time_reg[time_idx];
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	// Read data captured once per transfer and held to its end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			acc_ok_reg <= 1'b0;
		end else if (ce) begin
			if (psel && !acc_ok_reg) begin
				prdata_reg <= {24'h00_0000, rd_val};
				acc_ok_reg <= 1'b1;
			end else if (xfer_done) begin
				acc_ok_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Rate and oscillator control
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			rate_sel_reg <= rcs_pkg::RATE_RST;
			osc_ctrl_reg <= rcs_pkg::OSC_RST;
		end else if (ce) begin
			if (wr_en && (paddr == rcs_pkg::OFF_RATE_OSC)) begin
				rate_sel_reg <= pwdata[rcs_pkg::A_RATE_LSB +: 4];
				osc_ctrl_reg <= pwdata[rcs_pkg::A_OSC_LSB +: 3];
			end
		end
	end

	// ==========================================
	// Format and freeze bits, kept over the reset pin
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			freeze_reg <= 1'b0;
			binary_format_select_reg <= 1'b0;
			hour_24_reg <= 1'b0;
			summer_time_enable_reg <= 1'b0;
		end else if (ce) begin
			if (wr_en && (paddr == rcs_pkg::OFF_IRQ_FMT)) begin
				freeze_reg <= pwdata[rcs_pkg::B_FREEZE];
				binary_format_select_reg <= pwdata[rcs_pkg::B_BIN];
				hour_24_reg <= pwdata[rcs_pkg::B_HR24];
				summer_time_enable_reg <= pwdata[rcs_pkg::B_DST];
			end
		end
	end

	// ==========================================
	// Enables cleared by the reset pin
	always_ff @(posedge pclk or negedge pin_rst_n) begin
		if (!pin_rst_n) begin
			periodic_irq_enable_reg <= 1'b0;
			alarm_irq_enable_reg <= 1'b0;
			update_done_irq_enable_reg <= 1'b0;
			square_wave_enable_reg <= 1'b0;
		end else if (ce) begin
			if (wr_en && (paddr == rcs_pkg::OFF_IRQ_FMT)) begin
				periodic_irq_enable_reg <= pwdata[rcs_pkg::B_PIE];
				alarm_irq_enable_reg <= pwdata[rcs_pkg::B_AIE];
				update_done_irq_enable_reg <= pwdata[rcs_pkg::B_UIE] && !pwdata[rcs_pkg::B_FREEZE];
				square_wave_enable_reg <= pwdata[rcs_pkg::B_SQUARE_WAVE_ENABLE];
			end
		end
	end

	// ==========================================
	// Square-wave output
	always_ff @(posedge pclk or negedge pin_rst_n) begin
		if (!pin_rst_n) begin
			sqw_reg <= 1'b0;
		end else if (ce) begin
			sqw_reg <= square_wave_enable_reg && div_status.tap_level;
		end
	end

	assign square_wave_out = sqw_reg;

	// ==========================================
	// Time advance with summer-time steps
	function automatic logic [8:0] bump(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] low, input logic bcd);
		if (v == top) begin
			bump = {1'b1, low};
		end else if (bcd && (v[3:0] == 4'h9)) begin
			bump = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bump = {1'b0, v + 8'h01};
		end
	endfunction

	always_comb begin
		logic bcd;
		logic [7:0] m59;
		logic [7:0] twelve;
		logic [8:0] s_b;
		logic [8:0] m_b;
		logic [8:0] h_b;
		logic at_159;
		logic dst_day;
		h_b = 9'h000;
		bcd = !binary_format_select_reg;
		m59 = bcd ? 8'h59 : 8'h3B;
		twelve = bcd ? 8'h12 : 8'h0C;
		s_b = bump(time_reg[rcs_pkg::TI_SEC], m59, 8'h00, bcd);
		m_b = bump(time_reg[rcs_pkg::TI_MIN], m59, 8'h00, bcd);
		if (hour_24_reg) begin
			h_b = bump(time_reg[rcs_pkg::TI_HOUR], bcd ? 8'h23 : 8'h17, 8'h00, bcd);
		end else begin
			h_b = bump({1'b0, time_reg[rcs_pkg::TI_HOUR][6:0]}, twelve, 8'h01, bcd);
			h_b[7] = time_reg[rcs_pkg::TI_HOUR][7] ^ (h_b[7:0] == twelve);
		end
		sec_next = s_b[7:0];
		min_next = s_b[8] ? m_b[7:0] : time_reg[rcs_pkg::TI_MIN];
		hour_next = (s_b[8] && m_b[8]) ? h_b[7:0] : time_reg[rcs_pkg::TI_HOUR];
		at_159 = (time_reg[rcs_pkg::TI_HOUR] == 8'h01) && (time_reg[rcs_pkg::TI_MIN] == m59)
			&& (time_reg[rcs_pkg::TI_SEC] == m59);
		dst_day = summer_time_enable_reg && (time_reg[rcs_pkg::TI_WDAY] == 8'h01);
		fall_day = dst_day && (time_reg[rcs_pkg::TI_MONTH] == (bcd ? 8'h10 : 8'h0A))
			&& (time_reg[rcs_pkg::TI_DATE] >= (bcd ? 8'h25 : 8'h19));
		fall_hit = 1'b0;
		if (at_159 && dst_day && (time_reg[rcs_pkg::TI_MONTH] == 8'h04)
			&& (time_reg[rcs_pkg::TI_DATE] <= 8'h07)) begin
			hour_next = 8'h03;
			min_next = 8'h00;
			sec_next = 8'h00;
		end else if (at_159 && fall_day && !fall_done_reg) begin
			hour_next = 8'h01;
			min_next = 8'h00;
			sec_next = 8'h00;
			fall_hit = 1'b1;
		end
	end

	// Alarm compared against the time being transferred
	always_comb begin
		alarm_match = 1'b1;
		for (int k = 0; k < 3; k++) begin
			logic [7:0] al;
			logic [7:0] cur;
			al = time_reg[2 * k + 1];
			cur = (k == 0) ? sec_next : ((k == 1) ? min_next : hour_next);
			if ((al[7:6] != 2'b11) && (al != cur)) begin
				alarm_match = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			for (int i = 0; i < rcs_pkg::TIME_ENTRIES; i++) begin
				time_reg[i] <= rcs_pkg::TIME_RST;
			end
			fall_done_reg <= 1'b0;
		end else if (ce) begin
			if (transfer) begin
				time_reg[rcs_pkg::TI_SEC] <= sec_next;
				time_reg[rcs_pkg::TI_MIN] <= min_next;
				time_reg[rcs_pkg::TI_HOUR] <= hour_next;
				if (fall_hit) begin
					fall_done_reg <= 1'b1;
				end else if (!fall_day) begin
					fall_done_reg <= 1'b0;
				end
			end
			if (wr_en && time_hit) begin
				time_reg[time_idx] <= pwdata[7:0];
			end
		end
	end

	// ==========================================
	// Interrupt flags
	assign events = {div_status.tap_edge, transfer && alarm_match, div_status.sec_tick};

	always_ff @(posedge pclk or negedge pin_rst_n) begin
		if (!pin_rst_n) begin
			flags_reg <= 3'b000;
			pend_reg <= 3'b000;
		end else if (ce) begin
			if (rd_flags && xfer_done) begin
				flags_reg <= pend_reg | events;
				pend_reg <= 3'b000;
			end else if (rd_flags) begin
				pend_reg <= pend_reg | events;
			end else begin
				flags_reg <= flags_reg | pend_reg | events;
				pend_reg <= 3'b000;
			end
		end
	end

	assign interrupt_pending_flag = |(flags_reg & {periodic_irq_enable_reg,
		alarm_irq_enable_reg, update_done_irq_enable_reg});
	assign irq_n = !interrupt_pending_flag;

	// ==========================================
	// Battery-good input, filtered
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			batt_sync_reg <= 3'b000;
			battery_good_flag_reg <= 1'b0;
		end else if (ce) begin
			batt_sync_reg <= {batt_sync_reg[1:0], battery_good_in};
			if (batt_sync_reg[1] == batt_sync_reg[2]) begin
				battery_good_flag_reg <= batt_sync_reg[2];
			end
		end
	end

endmodule // rcs_top
`default_nettype wire

// ==== rcs_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker
module rcs_monitor #(
	parameter int OSC_DIV = rcs_pkg::OSC_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic battery_good_in,
	input wire logic irq_n,
	input wire logic square_wave_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !por_n);
	logic rd_done;
	logic mapped;
	assign rd_done = psel && penable && pready && !pwrite;
	assign mapped = paddr[1:0] == 2'b00 && paddr < rcs_pkg::OFF_TIME_END;

	a_stall_no_ready: assert property (!ce |-> !pready)
		else $error("ready while clock enable low");
	a_ready_no_wait: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
		else $error("access phase not answered at once");
	a_slverr_map: assert property (pready |-> pslverr == !mapped)
		else $error("error response does not match address map");
	a_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_flags_low_zero: assert property (rd_done && paddr == rcs_pkg::OFF_FLAGS |-> prdata[3:0] == 4'h0)
		else $error("unused flag bits not zero");
	a_batt_bits_zero: assert property (rd_done && paddr == rcs_pkg::OFF_BATTERY |-> prdata[6:0] == 7'h00)
		else $error("unused battery bits not zero");
	a_pending_pin: assert property (rd_done && paddr == rcs_pkg::OFF_FLAGS |-> prdata[7] == !irq_n)
		else $error("pending flag and interrupt pin disagree");
	a_irq_hold_read: assert property (psel && !penable && ce && !pwrite && paddr == rcs_pkg::OFF_FLAGS ##1 penable |-> $stable(irq_n))
		else $error("interrupt pin moved during flag read");
	a_irq_reset_idle: assert property ($rose(presetn) |-> irq_n)
		else $error("interrupt active right after reset");
	a_sqw_reset_low: assert property ($rose(presetn) |-> !square_wave_out)
		else $error("square wave active right after reset");
endmodule // rcs_monitor

bind rcs_top rcs_monitor #(.OSC_DIV(OSC_DIV)) mon_u (.pclk(pclk), .presetn(presetn),
	.por_n(por_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.battery_good_in(battery_good_in), .irq_n(irq_n), .square_wave_out(square_wave_out));
`default_nettype wire

// ==== rcs_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host bus master
module rcs_host_model (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [7:0] paddr,
	output var logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer, then one idle cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // rcs_host_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int DIV = 2;
	localparam logic [7:0] A_RATE = rcs_pkg::OFF_RATE_OSC;
	localparam logic [7:0] A_FMT = rcs_pkg::OFF_IRQ_FMT;
	localparam logic [7:0] A_FLAGS = rcs_pkg::OFF_FLAGS;
	localparam logic [7:0] A_BATT = rcs_pkg::OFF_BATTERY;
	localparam logic [7:0] A_SEC = rcs_pkg::OFF_TIME_BASE;
	logic pclk;
	logic presetn;
	logic por_n;
	logic ce;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic battery_good_in;
	logic irq_n;
	logic square_wave_out;
	int fail_count;
	int n_compared;
	int cyc = 0;

	// ==========================================
	// Clock and instances
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	rcs_top #(.OSC_DIV(DIV)) dut_u (.pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.battery_good_in(battery_good_in), .irq_n(irq_n), .square_wave_out(square_wave_out));
	rcs_host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ==========================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		host_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		host_u.xfer(1'b0, a, 32'h0, q, e);
		check(q, exp);
	endtask
	task automatic flush();
		repeat (4) @(posedge pclk);
		wr(8'h50, 32'h0);
		rd_any();
	endtask
	task automatic rd_any();
		logic [31:0] q;
		logic e;
		host_u.xfer(1'b0, A_FLAGS, 32'h0, q, e);
	endtask
	task automatic irq_is(input logic v);
		@(negedge pclk);
		check({31'h0, irq_n}, {31'h0, v});
		@(posedge pclk);
	endtask
	task automatic sqw_count(input int exp_n, input logic exp_lvl);
		logic s;
		int n;
		n = 0;
		@(negedge pclk);
		s = square_wave_out;
		repeat (64) begin
			@(negedge pclk);
			if (square_wave_out !== s) n++;
			s = square_wave_out;
		end
		@(posedge pclk);
		check(32'(n), 32'(exp_n));
		check({31'h0, s}, {31'h0, exp_lvl});
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset_map();
		logic [31:0] q;
		logic e;
		rd(A_RATE, 32'h0);
		wr(A_RATE, 32'h80);
		rd(A_RATE, 32'h0);
		wr(A_BATT, 32'h00);
		wr(A_FLAGS, 32'hFF);
		rd(A_BATT, 32'h80);
		rd(A_FLAGS, 32'h0);
		host_u.xfer(1'b0, 8'h40, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		battery_good_in <= 1'b0;
		repeat (6) @(posedge pclk);
		rd(A_BATT, 32'h0);
		battery_good_in <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask
	task automatic t_keep_on_reset();
		wr(A_RATE, 32'h0F);
		wr(A_FMT, 32'h7F);
		rd(A_FMT, 32'h7F);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_RATE, 32'h0F);
		fork
			rd(A_FMT, 32'h07);
			begin
				@(posedge pclk);
				ce <= 1'b0;
				repeat (3) @(posedge pclk);
				ce <= 1'b1;
			end
		join
	endtask
	task automatic t_freeze();
		wr(A_FMT, 32'h10);
		rd(A_FMT, 32'h10);
		wr(A_FMT, 32'h90);
		rd(A_FMT, 32'h80);
		wr(A_FMT, 32'h00);
	endtask
	task automatic t_periodic();
		wr(A_RATE, 32'h63);
		flush();
		repeat (40) @(posedge pclk);
		rd(A_FLAGS, 32'h0);
		wr(A_RATE, 32'h03);
		flush();
		repeat (40) @(posedge pclk);
		rd(A_FLAGS, 32'h0);
		wr(A_RATE, 32'h23);
		flush();
		repeat (40) @(posedge pclk);
		rd(A_FLAGS, 32'h40);
		repeat (20) @(posedge pclk);
		wr(A_FMT, 32'h48);
		irq_is(1'b0);
		sqw_count(16, 1'b1);
		wr(A_FMT, 32'h40);
		sqw_count(0, 1'b0);
		rd(A_FLAGS, 32'hC0);
		wr(A_RATE, 32'h20);
		flush();
		repeat (40) @(posedge pclk);
		rd(A_FLAGS, 32'h0);
		irq_is(1'b1);
		wr(A_FMT, 32'h00);
	endtask
	task automatic t_update();
		logic [31:0] q;
		logic e;
		int t0;
		int last0;
		int k;
		logic seen1;
		wr(A_RATE, 32'h60);
		wr(A_SEC, 32'h05);
		for (int i = 1; i < 6; i += 2) wr(A_SEC + 8'(4 * i), 32'hC0);
		wr(A_FMT, 32'h10);
		flush();
		wr(A_RATE, 32'h20);
		t0 = cyc;
		last0 = cyc;
		seen1 = 1'b0;
		k = 0;
		while (irq_n !== 1'b0 && k < 20000) begin
			host_u.xfer(1'b0, A_RATE, 32'h0, q, e);
			if (q[7] === 1'b1) seen1 = 1'b1;
			else last0 = cyc;
			k++;
		end
		check({31'h0, seen1}, 32'h1);
		check(32'(cyc - last0 >= (rcs_pkg::UIP_LEAD_TICKS - 1) * DIV), 32'h1);
		check(32'((cyc - t0 - rcs_pkg::RESTART_TICKS * DIV) / 9), 32'h0);
		rd(A_FLAGS, 32'hB0);
		rd(A_SEC, 32'h06);
		rd(A_FLAGS, 32'h0);
		irq_is(1'b1);
	endtask

	// ==========================================
	// Run control
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		print_verdict();
	end
	initial begin
		presetn = 1'b0;
		por_n = 1'b0;
		ce = 1'b1;
		battery_good_in = 1'b1;
		fail_count = 0;
		n_compared = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		t_reset_map();
		t_keep_on_reset();
		t_freeze();
		t_periodic();
		t_update();
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
